// ---- logic/parallel_port_pkg.sv ----
package parallel_port_pkg;
  // register byte offsets
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  READ_TARGET_ADDR_BITS_OFS    = 8'h04;
  localparam logic [7:0]  RDATA_OFS    = 8'h08;
  localparam logic [7:0]  SHDATA_OFS   = 8'h0C;
  // port control fields
  localparam int          START_BIT    = 0;
  localparam int          CSF_LO       = 6;
  localparam int          CSF_HI       = 7;
  localparam int          BUSY_BIT     = 8;
  localparam int          DUAL_BIT     = 17;
  localparam logic [31:0] CTRL_WMASK   = 32'h0002_00C0;
  localparam logic [31:0] BUSY_MASK    = 32'h0000_0100;
  localparam logic [31:0] ADDR_WMASK   = 32'h0000_FFFF;
  localparam logic [31:0] DATA_WMASK   = 32'h0000_FFFF;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
  localparam logic [15:0] PAD_RESET    = 16'h0000;
  // select function encodings
  localparam logic [1:0]  CSF_ADDR     = 2'h0;
  localparam logic [1:0]  CSF_CS2      = 2'h1;
  localparam logic [1:0]  CSF_BOTH     = 2'h2;
  // read strobe timing
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          STROBE_NS     = 300;
  localparam int          STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  STROBE_LAST   = 2'(STROBE_CYC - 1);
  localparam logic [1:0]  CNT_ZERO      = 2'h0;
  localparam logic [1:0]  CNT_ONE       = 2'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_CAPTURE} read_state_e;
endpackage : parallel_port_pkg

// ---- logic/parallel_port_dual_buffer_read_regs.sv ----
// Summary of operation
// RL1 - select function 10 or 01: read address bit 15 drives select two.
// RL2 - select function 00: read address bit 15 is target address bit 15.
// RL3 - select function 10: read address bit 14 drives select one.
// RL4 - select function 00 or 01: read address bit 14 is address bit 14.
// RL5 - read address bits 13 to 0 are writable and cleared at reset.
// RL6 - read address register is used only while dual buffering is enabled.
// RL7 - dual buffering: returned read data lands in the read input data register.
// RL8 - dual buffering off: returned read data lands in the shared data register.
// RL9 - select function chooses address bits or selects on the two top pads.
// RL10 - dual read drives pads from read address, then captures returned data.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
module parallel_port_dual_buffer_read_regs
  import parallel_port_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic [15:0] shared_address_i,
  output logic      [15:0] port_address_pads_o,
  output logic             read_select_two_o,
  output logic             read_select_one_o,
  output logic             read_strobe_o,
  input  wire logic [15:0] read_returned_data_i
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r & mask;
  endfunction : merge

  logic        ack_q;
  logic [31:0] readdata_q;
  logic [31:0] port_control_reg_q;
  logic [31:0] read_target_address_q;
  logic [31:0] read_input_data_q;
  logic [31:0] shared_data_input_reg_q;
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic [15:0] sync3_q;
  logic [15:0] pads_q;
  logic        sel_two_q;
  logic        sel_one_q;
  logic        strobe_q;
  logic [1:0]  cnt_q;
  logic [1:0]  cnt_d;
  read_state_e state_q;
  read_state_e state_d;

  // bus handshake: one wait cycle per access
  wire req     = read_i | write_i;
  wire wr_take = write_i & ack_q;
  assign waitrequest_o = req & ~ack_q;
  assign readdata_o    = readdata_q;

  // address decode
  wire hit_ctrl   = address_i == CTRL_OFS;
  wire hit_read_target_addr_bits  = address_i == READ_TARGET_ADDR_BITS_OFS;
  wire hit_rdata  = address_i == RDATA_OFS;
  wire hit_shdata = address_i == SHDATA_OFS;

  wire        dual_buffer_enable    = port_control_reg_q[DUAL_BIT];
  wire [1:0]  select_function_field = port_control_reg_q[CSF_HI:CSF_LO];
  wire        busy                  = state_q != ST_IDLE;
  wire        start_req = wr_take & hit_ctrl & byteenable_i[0] & writedata_i[START_BIT];
  wire        agree     = sync2_q == sync3_q;
  wire        capture   = (state_q == ST_CAPTURE) & agree;

  // address source and pad decode
  wire [15:0] src_addr = dual_buffer_enable ? read_target_address_q[15:0] : shared_address_i; // RL6
  wire        cs2_mode = (select_function_field == CSF_BOTH) |
                         (select_function_field == CSF_CS2);
  wire        cs1_mode = select_function_field == CSF_BOTH;
  wire        a15_mode = select_function_field == CSF_ADDR;
  wire        a14_mode = (select_function_field == CSF_ADDR) |
                         (select_function_field == CSF_CS2);
  wire        pad15    = a15_mode & src_addr[15]; // RL2 RL9
  wire        pad14    = a14_mode & src_addr[14]; // RL4 RL9
  wire [15:0] pads_d   = {pad15, pad14, src_addr[13:0]}; // RL5 RL10
  wire        sel_two_d = busy & cs2_mode & src_addr[15]; // RL1 RL9
  wire        sel_one_d = busy & cs1_mode & src_addr[14]; // RL3 RL9

  // register next values; hardware capture wins over a software write
  wire [31:0] ctrl_rd  = port_control_reg_q | (busy ? BUSY_MASK : REG_RESET);
  wire [31:0] ctrl_d   = (wr_take & hit_ctrl) ?
                         merge(port_control_reg_q, writedata_i, byteenable_i, CTRL_WMASK) :
                         port_control_reg_q;
  wire [31:0] read_target_addr_bits_d  = (wr_take & hit_read_target_addr_bits) ?
                         merge(read_target_address_q, writedata_i, byteenable_i, ADDR_WMASK) :
                         read_target_address_q; // RL5
  wire [31:0] rdata_d  = (capture & dual_buffer_enable) ? {16'h0000, sync3_q} : // RL7
                         (wr_take & hit_rdata) ?
                         merge(read_input_data_q, writedata_i, byteenable_i, DATA_WMASK) :
                         read_input_data_q;
  wire [31:0] shdata_d = (capture & ~dual_buffer_enable) ? {16'h0000, sync3_q} : // RL8
                         (wr_take & hit_shdata) ?
                         merge(shared_data_input_reg_q, writedata_i, byteenable_i, DATA_WMASK) :
                         shared_data_input_reg_q;
  wire [31:0] rd_mux   = hit_ctrl   ? ctrl_rd :
                         hit_read_target_addr_bits  ? read_target_address_q :
                         hit_rdata  ? read_input_data_q :
                         hit_shdata ? shared_data_input_reg_q : REG_RESET;

  // read transfer sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        cnt_d = CNT_ZERO;
        if (start_req) begin
          state_d = ST_STROBE; // RL10
        end
      end
      ST_STROBE: begin
        cnt_d = cnt_q + CNT_ONE;
        if (cnt_q == STROBE_LAST) begin
          state_d = ST_CAPTURE;
          cnt_d   = CNT_ZERO;
        end
      end
      ST_CAPTURE: begin
        if (agree) begin
          state_d = ST_IDLE; // RL10
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ack_q      <= 1'b0;
      readdata_q <= REG_RESET;
    end else begin
      ack_q      <= req & ~ack_q;
      readdata_q <= (req & ~ack_q) ? rd_mux : readdata_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      port_control_reg_q      <= REG_RESET;
      read_target_address_q   <= REG_RESET;
      read_input_data_q       <= REG_RESET;
      shared_data_input_reg_q <= REG_RESET;
    end else begin
      port_control_reg_q      <= ctrl_d;
      read_target_address_q   <= read_target_addr_bits_d;
      read_input_data_q       <= rdata_d;
      shared_data_input_reg_q <= shdata_d;
    end
  end

  // returned data pin synchroniser
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync1_q <= PAD_RESET;
      sync2_q <= PAD_RESET;
      sync3_q <= PAD_RESET;
    end else begin
      sync1_q <= read_returned_data_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q   <= ST_IDLE;
      cnt_q     <= CNT_ZERO;
      pads_q    <= PAD_RESET;
      sel_two_q <= 1'b0;
      sel_one_q <= 1'b0;
      strobe_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      pads_q    <= pads_d;
      sel_two_q <= sel_two_d;
      sel_one_q <= sel_one_d;
      strobe_q  <= state_d == ST_STROBE;
    end
  end

  assign port_address_pads_o = pads_q;
  assign read_select_two_o   = sel_two_q;
  assign read_select_one_o   = sel_one_q;
  assign read_strobe_o       = strobe_q;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_SEL_TWO: assert property (busy && cs2_mode |=> // RL1
    read_select_two_o == $past(src_addr[15]))
    else $error("select two does not follow address bit 15");

  AST_PAD15_ADDR: assert property (a15_mode && !busy |=> // RL2
    port_address_pads_o[15] == $past(src_addr[15]) && !read_select_two_o)
    else $error("pad 15 is not address bit 15");

  AST_SEL_ONE: assert property (busy && cs1_mode |=> // RL3
    read_select_one_o == $past(src_addr[14]) && port_address_pads_o[14] == 1'b0)
    else $error("select one does not follow address bit 14");

  AST_PAD14_ADDR: assert property (a14_mode |=> // RL4
    port_address_pads_o[14] == $past(src_addr[14]) && !read_select_one_o)
    else $error("pad 14 is not address bit 14");

  AST_LOW_ADDR: assert property (dual_buffer_enable |=> // RL5
    port_address_pads_o[13:0] == $past(read_target_address_q[13:0]))
    else $error("low pads do not follow read address");

  AST_READ_TARGET_ADDR_BITS_WRITE: assert property (wr_take && hit_read_target_addr_bits && byteenable_i == 4'hF |=> // RL5
    read_target_address_q == (ADDR_WMASK & $past(writedata_i)))
    else $error("read address write lost");

  AST_NO_DUAL_SRC: assert property (!dual_buffer_enable |=> // RL6
    port_address_pads_o[13:0] == $past(shared_address_i[13:0]))
    else $error("read address used while dual buffering is off");

  AST_DUAL_CAPTURE: assert property (capture && dual_buffer_enable |=> // RL7
    read_input_data_q[15:0] == $past(sync3_q) && $stable(shared_data_input_reg_q))
    else $error("dual read data not captured");

  AST_SHARED_CAPTURE: assert property (capture && !dual_buffer_enable |=> // RL8
    shared_data_input_reg_q[15:0] == $past(sync3_q) && $stable(read_input_data_q))
    else $error("shared read data not captured");

  AST_IDLE_SELECTS: assert property (!busy |=> !read_select_two_o && !read_select_one_o) // RL9
    else $error("select active outside a transfer");

  AST_STROBE_SEQ: assert property (start_req && !busy |=> // RL10
    read_strobe_o [*3] ##1 !read_strobe_o ##[0:20] !busy)
    else $error("read strobe sequence wrong");

  AST_READ_TARGET_ADDR_BITS_UPPER: assert property ( // RL5
    read_target_address_q[31:16] == 16'h0000)
    else $error("read address upper bits not zero");

  AST_READ_TARGET_ADDR_BITS_HOLD: assert property (!(wr_take && hit_read_target_addr_bits) |=> // RL5
    $stable(read_target_address_q))
    else $error("read address changed without a write");

  AST_CTRL_MASK: assert property ( // RL6
    (port_control_reg_q & ~CTRL_WMASK) == REG_RESET)
    else $error("control register holds unmapped bits");

  AST_RDATA_UPPER: assert property ( // RL7
    read_input_data_q[31:16] == 16'h0000)
    else $error("read input data upper bits not zero");

  AST_RDATA_WRITE: assert property (wr_take && hit_rdata && !capture && byteenable_i == 4'hF |=> // RL7
    read_input_data_q == (DATA_WMASK & $past(writedata_i)))
    else $error("read input data write lost");

  AST_DUAL_HOLD: assert property (dual_buffer_enable && !(wr_take && hit_shdata) |=> // RL7
    $stable(shared_data_input_reg_q))
    else $error("shared data changed while dual buffering is on");

  AST_SHDATA_UPPER: assert property ( // RL8
    shared_data_input_reg_q[31:16] == 16'h0000)
    else $error("shared data upper bits not zero");

  AST_NO_DUAL_RDATA: assert property (!dual_buffer_enable && !(wr_take && hit_rdata) |=> // RL8
    $stable(read_input_data_q))
    else $error("read input data changed while dual buffering is off");

  AST_SEL_TWO_OFF: assert property (a15_mode |=> // RL2
    !read_select_two_o)
    else $error("select two active in address mode");

  AST_SEL_ONE_OFF: assert property (!cs1_mode |=> // RL4
    !read_select_one_o)
    else $error("select one active outside its mode");

  AST_PAD_TOP_SELECTS: assert property (cs1_mode |=> // RL9
    port_address_pads_o[15:14] == 2'h0)
    else $error("top pads driven while used as selects");

  AST_STROBE_IDLE: assert property (!busy && !start_req |=> // RL10
    !read_strobe_o)
    else $error("read strobe active outside a transfer");

  CVR_DUAL_READ: cover property (capture && dual_buffer_enable);
  CVR_SHARED_READ: cover property (capture && !dual_buffer_enable);
  CVR_BOTH_SELECTS: cover property (read_select_two_o && read_select_one_o);
  CVR_CAPTURE_VS_WRITE: cover property (capture && wr_take && hit_rdata);
  CVR_SEL_TWO_ONLY: cover property (read_select_two_o && !read_select_one_o);

endmodule : parallel_port_dual_buffer_read_regs

// ---- testbench/periph_model.sv ----
module periph_model (
  input  wire logic        clk_i,
  input  wire logic        strobe_i,
  input  wire logic [15:0] value_i,
  output logic      [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  hold_q = 2'h0;
  logic [15:0] junk_q = 16'h1234;
  // data held while strobed plus two cycles, then a pattern that changes every cycle
  always_ff @(posedge clk_i) begin
    hold_q <= strobe_i ? 2'h2 : ((hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0);
    junk_q <= ~junk_q ^ 16'h5A3C;
  end
  assign data_o = (strobe_i || hold_q != 2'h0) ? value_i : junk_q;
endmodule : periph_model

// ---- testbench/parallel_port_dual_buffer_read_regs_tb_top.sv ----
module parallel_port_dual_buffer_read_regs_tb_top;
  import parallel_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  address = 8'h00;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_r;
  logic [15:0] shared_addr = 16'h0;
  logic [15:0] pads;
  logic        sel2;
  logic        sel1;
  logic        strobe;
  logic [15:0] pdata;
  logic [15:0] pval = 16'h0;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          seed = 91265;
  int          mdl[4];
  int          rdq[$];
  int          s_len = 0;
  logic [3:0]  be = 4'hF;
  always #50 clk = ~clk;
  parallel_port_dual_buffer_read_regs dut (
    .sys_clk_i(clk), .sys_rst_i(rst), .address_i(address), .read_i(rd), .write_i(wr),
    .writedata_i(wdata), .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(wait_r),
    .shared_address_i(shared_addr), .port_address_pads_o(pads), .read_select_two_o(sel2),
    .read_select_one_o(sel1), .read_strobe_o(strobe), .read_returned_data_i(pdata));
  periph_model peer (.clk_i(clk), .strobe_i(strobe), .value_i(pval), .data_o(pdata));
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    address <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wait_r !== 1'h0);
    q = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask : bus
  function automatic logic [17:0] decode(input logic [1:0] f, input logic [15:0] a);
    case (f)
      CSF_ADDR: return {2'h0, a};
      CSF_CS2:  return {a[15], 1'h0, 1'h0, a[14:0]};
      CSF_BOTH: return {a[15], a[14], 2'h0, a[13:0]};
      default:  return {4'h0, a[13:0]};
    endcase
  endfunction : decode
  always @(posedge clk) begin
    if (strobe === 1'h1) begin
      s_len <= s_len + 1;
    end else if (s_len != 0) begin
      chk(32'(s_len), 32'(STROBE_CYC));
      s_len <= 0;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    logic [31:0] q;
    logic [15:0] ad;
    logic        dual;
    logic [31:0] wd;
    mdl = '{0, 0, 0, 0};
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      bus(1'h0, 8'(i * 4), 32'h0, q);
      chk(q, 32'h0);
    end
    bus(1'h1, 8'h10, 32'hFFFF_FFFF, q);
    bus(1'h0, 8'h10, 32'h0, q);
    chk(q, 32'h0);
    for (int it = 0; it < 8; it++) begin
      dual = (it < 4);
      ad = 16'($random(seed));
      pval <= 16'($random(seed));
      shared_addr <= 16'($random(seed));
      bus(1'h1, READ_TARGET_ADDR_BITS_OFS, {16'hFFFF, ad}, q);
      bus(1'h0, READ_TARGET_ADDR_BITS_OFS, 32'h0, q);
      chk(q, {16'h0, ad});
      bus(1'h1, CTRL_OFS, (32'(dual) << DUAL_BIT) | (32'(it % 4) << CSF_LO) | 32'h1, q);
      while (strobe !== 1'h1) begin
        @(posedge clk);
      end
      rdq.push_back(int'(pval));
      @(posedge clk);
      @(negedge clk);
      chk({sel2, sel1, pads}, decode(2'(it % 4), dual ? ad : shared_addr));
      do begin
        bus(1'h0, CTRL_OFS, 32'h0, q);
      end while (q[BUSY_BIT] !== 1'h0);
      chk({30'h0, sel2, sel1}, 32'h0);
      mdl[dual ? 2 : 3] = rdq.pop_front();
      bus(1'h0, RDATA_OFS, 32'h0, q);
      chk(q, 32'(mdl[2]));
      bus(1'h0, SHDATA_OFS, 32'h0, q);
      chk(q, 32'(mdl[3]));
    end
    wd = 32'($random(seed));
    be <= 4'h1;
    bus(1'h1, READ_TARGET_ADDR_BITS_OFS, wd, q);
    be <= 4'hF;
    bus(1'h0, READ_TARGET_ADDR_BITS_OFS, 32'h0, q);
    chk(q, {16'h0, ad[15:8], wd[7:0]});
    bus(1'h1, RDATA_OFS, wd, q);
    bus(1'h0, RDATA_OFS, 32'h0, q);
    chk(q, wd & DATA_WMASK);
    results();
  end
endmodule : parallel_port_dual_buffer_read_regs_tb_top
